// ===== inc/css_defines.svh
// Constants for the clocked serial slave channel: widths, counts and reset values.
// Assumes inclusion by its bare name from the package and the design files.
`ifndef CSS_DEFINES_SVH
`define CSS_DEFINES_SVH

`define CSS_WORD_W 8
`define CSS_CNT_W 3
`define CSS_LAST_BIT8 3'h7
`define CSS_LAST_BIT7 3'h6
`define CSS_SYNC_W 3
`define CSS_WORD_RST 8'h00
`define CSS_SCK_RATIO 6

`endif

// ===== inc/css_pkg.sv
// Types shared by the serial slave core, its link stage and their carrier.
// Assumes the defines header is on the include path.
`include "css_defines.svh"

package css_pkg;

    // One data word as it sits in the buffers.
    typedef logic [`CSS_WORD_W-1:0] css_word_t;

    // Channel operation state, one-hot.
    typedef enum logic [1:0] {
        CSS_CH_STOPPED = 2'b01,
        CSS_CH_RUNNING = 2'b10
    } css_chan_t;

endpackage

// ===== inc/css_link_if.sv
// Carrier between the system-clock core and the serial-clock link stage.
// Assumes the core holds every field that it drives stable while the link uses it.
`timescale 1ns/100ps

interface css_link_if;
    css_pkg::css_word_t tx_word;
    logic tx_first;
    logic ld_tog;
    css_pkg::css_word_t rx_word;
    logic rx_tog;
    logic dap;
    logic ckp;
    logic len7;
    logic link_rst;

    modport core (
        output tx_word,
        output tx_first,
        output dap,
        output ckp,
        output len7,
        output link_rst,
        input ld_tog,
        input rx_word,
        input rx_tog
    );

    modport link (
        input tx_word,
        input tx_first,
        input dap,
        input ckp,
        input len7,
        input link_rst,
        output ld_tog,
        output rx_word,
        output rx_tog
    );
endinterface

// ===== rtl/css_link.sv
// Shift stage of the serial slave, clocked by the master's serial clock.
// Assumes configuration fields stay still while the channel runs and that
// the reset from the core is released only while the serial clock is idle.
`timescale 1ns/100ps

`include "css_defines.svh"

module css_link (
    input wire logic sck,
    input wire logic sin,
    output logic so,
    css_link_if.link lk
);
    logic [`CSS_CNT_W-1:0] cnt_ff;
    css_pkg::css_word_t rx_sr_ff;
    css_pkg::css_word_t rx_word_ff;
    css_pkg::css_word_t tx_sr_ff;
    logic rx_tog_ff;
    logic ld_tog_ff;

    // Sampling edge is the rising edge of this clock, shifting the falling one.
    wire eclk = sck ^ lk.ckp ^ lk.dap;
    wire [`CSS_CNT_W-1:0] last_bit = lk.len7 ? `CSS_LAST_BIT7 : `CSS_LAST_BIT8;
    wire word_end = (cnt_ff == last_bit);
    wire load_now = (cnt_ff == {2'b00, lk.dap});
    wire [`CSS_WORD_W-1:0] rx_next = {sin, rx_sr_ff[`CSS_WORD_W-1:1]};

    // Sample the serial input and count bits of the word.
    always_ff @(posedge eclk or posedge lk.link_rst) begin
        if (lk.link_rst) begin
            cnt_ff <= 3'h0;
            rx_sr_ff <= `CSS_WORD_RST;
            rx_word_ff <= `CSS_WORD_RST;
            rx_tog_ff <= 1'b0;
        end else begin
            rx_sr_ff <= rx_next;
            cnt_ff <= word_end ? 3'h0 : cnt_ff + 3'h1;
            if (word_end) begin
                rx_word_ff <= rx_next;
                rx_tog_ff <= ~rx_tog_ff;
            end
        end
    end

    // Load the word at its start, then shift one bit per serial clock.
    always_ff @(negedge eclk or posedge lk.link_rst) begin
        if (lk.link_rst) begin
            tx_sr_ff <= `CSS_WORD_RST;
            ld_tog_ff <= 1'b0;
        end else if (load_now) begin
            tx_sr_ff <= lk.dap ? {1'b0, lk.tx_word[`CSS_WORD_W-1:1]} : lk.tx_word;
            ld_tog_ff <= ~ld_tog_ff;
        end else begin
            tx_sr_ff <= {1'b0, tx_sr_ff[`CSS_WORD_W-1:1]};
        end
    end

    // With the early data phase the first bit stands before the clock starts.
    assign so = (lk.dap && cnt_ff == 3'h0) ? lk.tx_first : tx_sr_ff[0];
    assign lk.rx_word = rx_word_ff;
    assign lk.rx_tog = rx_tog_ff;
    assign lk.ld_tog = ld_tog_ff;

    chk_cnt_in_range: assert property (
        @(posedge eclk) disable iff (lk.link_rst) cnt_ff <= last_bit)
        else $error("bit counter passed the word length");
endmodule

// ===== rtl/css_slave.sv
// Serial slave channel: transmit buffer, receive register, flags and stop control.
// Assumes an external master drives SCK no faster than one sixth of CLK and
// that mode inputs change only while the channel is stopped.
`timescale 1ns/100ps

`include "css_defines.svh"

// Functional notes
// - Transmit shifts data out timed only by the master's clock; never generates it.
// - Receive captures serial input bits on the master's clock.
// - Event source: transfer end in single mode, buffer empty in continuous mode.
// - Overrun is the only error flagged.
// - Word length seven or eight bits; order MSB-first or LSB-first.
// - Master keeps serial clock at or below one sixth of the operation clock.
// - Data phase 0 outputs first bit at clock start; 1 half a period earlier.
// - Clock polarity selects non-inverted or inverted serial clock.
// - Writing data while the buffer is full replaces the buffered word.
// - Interrupt source selection stays writable while running.
// - Stop may skip waiting for the active flag; a word in flight is abandoned.
// - Stop trigger clears the channel enabled status.
// - Clearing serial output enable stops serial data reaching the serial output.
// - With output disabled, software sets static clock-out and data-out levels.
// - Removing the unit clock supply resets the whole unit.
module css_slave (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic UNIT_CLOCK_ON,
    input wire logic SCK,
    input wire logic SIN,
    output logic SO_OUT,
    output logic CKO_OUT,
    input wire logic START_TRIGGER,
    input wire logic STOP_TRIGGER,
    output logic CHANNEL_ENABLED_STATUS,
    input wire logic SERIAL_OUT_ENABLE_BIT,
    input wire logic DATA_OUT_LEVEL,
    input wire logic CLOCK_OUT_LEVEL,
    input wire logic DATA_PHASE_SEL,
    input wire logic CLOCK_POLARITY_SEL,
    input wire logic WORD_LEN7,
    input wire logic LSB_FIRST,
    input wire logic INTERRUPT_SOURCE_SEL,
    input wire logic TX_WRITE,
    input wire logic [7:0] TX_DATA,
    input wire logic RX_READ,
    output logic [7:0] RX_DATA,
    output logic BUFFER_FULL_FLAG,
    output logic TRANSFER_ACTIVE_FLAG,
    output logic OVERRUN_FLAG,
    input wire logic OVERRUN_CLEAR,
    output logic CHANNEL_EVENT
);
    // Reorders a word between wire order (bit 0 first) and data order.
    function automatic css_pkg::css_word_t css_order(
        input css_pkg::css_word_t w,
        input logic len7,
        input logic lsb
    );
        css_pkg::css_word_t r;
        r = w;
        if (!lsb) begin
            for (int i = 0; i < `CSS_WORD_W - 1; i++) begin
                r[i] = len7 ? w[6-i] : w[7-i];
            end
            r[`CSS_WORD_W-1] = len7 ? 1'b0 : w[0];
        end
        return r;
    endfunction

    css_link_if lk ();

    css_pkg::css_chan_t state_ff;
    css_pkg::css_chan_t nxt_state;
    logic link_rst_ff;
    logic dap_ff;
    logic ckp_ff;
    logic len7_ff;
    logic lsb_ff;
    css_pkg::css_word_t buf_ff;
    css_pkg::css_word_t word_ff;
    css_pkg::css_word_t rx_data_ff;
    logic full_ff;
    logic word_free_ff;
    logic unread_ff;
    logic ovf_ff;
    logic active_ff;
    logic event_ff;
    logic dol_ff;
    logic col_ff;
    logic link_so;

    // Removing the unit clock supply acts as a reset of the whole unit.
    wire rst = SRST | ~UNIT_CLOCK_ON;
    wire running = (state_ff == css_pkg::CSS_CH_RUNNING);
    wire sync_clr = rst | link_rst_ff;

    // Stop wins over start; a stop needs no wait for the active flag.
    always_comb begin
        nxt_state = state_ff;
        if (STOP_TRIGGER) begin
            nxt_state = css_pkg::CSS_CH_STOPPED;
        end else if (START_TRIGGER) begin
            nxt_state = css_pkg::CSS_CH_RUNNING;
        end
    end

    // Channel state and the reset held on the link stage while stopped.
    always_ff @(posedge CLK) begin
        if (rst) begin
            state_ff <= css_pkg::CSS_CH_STOPPED;
            link_rst_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            link_rst_ff <= (nxt_state != css_pkg::CSS_CH_RUNNING);
        end
    end

    // Mode fields are taken only while stopped so the link sees them still.
    always_ff @(posedge CLK) begin
        if (rst) begin
            dap_ff <= 1'b0;
            ckp_ff <= 1'b0;
            len7_ff <= 1'b0;
            lsb_ff <= 1'b0;
        end else if (!running) begin
            dap_ff <= DATA_PHASE_SEL;
            ckp_ff <= CLOCK_POLARITY_SEL;
            len7_ff <= WORD_LEN7;
            lsb_ff <= LSB_FIRST;
        end
    end

    // Static pin levels follow software only while serial output is disabled.
    always_ff @(posedge CLK) begin
        if (rst) begin
            dol_ff <= 1'b1;
            col_ff <= 1'b1;
        end else if (!SERIAL_OUT_ENABLE_BIT) begin
            dol_ff <= DATA_OUT_LEVEL;
            col_ff <= CLOCK_OUT_LEVEL;
        end
    end

    // Toggles from the link: index 0 marks a word load, index 1 a word done.
    wire [1:0] link_tog = {lk.rx_tog, lk.ld_tog};
    wire [1:0] tog_seen;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_sync
            logic [`CSS_SYNC_W-1:0] sync_ff;
            // Two flip-flops resolve the crossing; the third finds the edge.
            always_ff @(posedge CLK) begin
                if (sync_clr) begin
                    sync_ff <= 3'h0;
                end else begin
                    sync_ff <= {sync_ff[1:0], link_tog[g]};
                end
            end
            // Toggles stay several cycles apart only while the serial clock is slow enough.
            assign tog_seen[g] = sync_ff[2] ^ sync_ff[1];
        end
    endgenerate

    wire ld_seen = tog_seen[0];
    wire rx_seen = tog_seen[1];

    // A buffered word moves on once the link has taken the previous one.
    wire free_now = word_free_ff | ld_seen;
    wire move = full_ff & free_now & running;
    wire ovf_set = rx_seen & unread_ff & ~RX_READ;
    wire src_cont = INTERRUPT_SOURCE_SEL;
    wire evt_src = src_cont ? move : rx_seen;
    wire [`CSS_WORD_W-1:0] rx_wire = len7_ff ? {1'b0, lk.rx_word[7:1]} : lk.rx_word;

    // Transmit buffer: a write while full overwrites the waiting word.
    always_ff @(posedge CLK) begin
        if (rst) begin
            buf_ff <= `CSS_WORD_RST;
            full_ff <= 1'b0;
        end else begin
            if (TX_WRITE) begin
                buf_ff <= TX_DATA;
            end
            full_ff <= TX_WRITE | (full_ff & ~move);
        end
    end

    // Word handed to the link, already in wire order.
    always_ff @(posedge CLK) begin
        if (rst) begin
            word_ff <= `CSS_WORD_RST;
            word_free_ff <= 1'b1;
        end else begin
            if (move) begin
                word_ff <= css_order(buf_ff, len7_ff, lsb_ff);
            end
            word_free_ff <= ~running | (free_now & ~move);
        end
    end

    // Received word and its unread marker; a new word beats a read.
    always_ff @(posedge CLK) begin
        if (rst) begin
            rx_data_ff <= `CSS_WORD_RST;
            unread_ff <= 1'b0;
        end else begin
            if (rx_seen) begin
                rx_data_ff <= css_order(rx_wire, len7_ff, lsb_ff);
            end
            unread_ff <= rx_seen | (unread_ff & ~RX_READ);
        end
    end

    // Overrun is the only error; setting beats clearing.
    always_ff @(posedge CLK) begin
        if (rst) begin
            ovf_ff <= 1'b0;
        end else begin
            ovf_ff <= ovf_set | (ovf_ff & ~OVERRUN_CLEAR);
        end
    end

    // Active from a word's start until that word completes; a stop drops it at once.
    always_ff @(posedge CLK) begin
        if (rst || nxt_state != css_pkg::CSS_CH_RUNNING) begin
            active_ff <= 1'b0;
        end else begin
            active_ff <= ld_seen | (active_ff & ~rx_seen);
        end
    end

    // One-cycle channel event from the chosen source or an overrun.
    always_ff @(posedge CLK) begin
        if (rst) begin
            event_ff <= 1'b0;
        end else begin
            event_ff <= evt_src | ovf_set;
        end
    end

    // Fields carried to the link stage.
    assign lk.tx_word = word_ff;
    assign lk.tx_first = word_ff[0];
    assign lk.dap = dap_ff;
    assign lk.ckp = ckp_ff;
    assign lk.len7 = len7_ff;
    assign lk.link_rst = link_rst_ff;

    css_link u_link (
        .sck(SCK),
        .sin(SIN),
        .so(link_so),
        .lk(lk.link)
    );

    // With output disabled the pins show the static software levels.
    assign SO_OUT = SERIAL_OUT_ENABLE_BIT ? link_so : dol_ff;
    assign CKO_OUT = col_ff;
    assign CHANNEL_ENABLED_STATUS = running;
    assign RX_DATA = rx_data_ff;
    assign BUFFER_FULL_FLAG = full_ff;
    assign TRANSFER_ACTIVE_FLAG = active_ff;
    assign OVERRUN_FLAG = ovf_ff;
    assign CHANNEL_EVENT = event_ff;

    default clocking @(posedge CLK); endclocking
    default disable iff (rst);

    // A stop request, then the link held in reset.
    sequence stop_req;
        STOP_TRIGGER;
    endsequence

    sequence link_held;
        link_rst_ff [*2];
    endsequence

    chk_stop_clears_run: assert property (
        stop_req |=> !CHANNEL_ENABLED_STATUS && !TRANSFER_ACTIVE_FLAG)
        else $error("stop did not clear enabled status");

    chk_stop_abandons: assert property (
        stop_req ##1 !START_TRIGGER |-> link_held)
        else $error("link not held in reset after stop");

    chk_overrun_sets: assert property (
        ovf_set |=> OVERRUN_FLAG && CHANNEL_EVENT)
        else $error("overrun not flagged with an event");

    chk_overrun_cause: assert property (
        $rose(OVERRUN_FLAG) |-> $past(unread_ff) && $past(rx_seen))
        else $error("overrun set without an unread word");

    chk_single_event: assert property (
        rx_seen && !src_cont |=> CHANNEL_EVENT)
        else $error("transfer end event missing");

    chk_empty_event: assert property (
        move && src_cont && !TX_WRITE |=> CHANNEL_EVENT && !BUFFER_FULL_FLAG)
        else $error("buffer empty event or clear missing");

    chk_event_source: assert property (
        CHANNEL_EVENT |-> $past(evt_src) || $past(ovf_set))
        else $error("event without a cause");

    chk_overwrite_buf: assert property (
        TX_WRITE && BUFFER_FULL_FLAG |=> buf_ff == $past(TX_DATA) && BUFFER_FULL_FLAG)
        else $error("buffered word not replaced");

    chk_static_levels: assert property (
        !SERIAL_OUT_ENABLE_BIT ##1 !SERIAL_OUT_ENABLE_BIT |-> SO_OUT == $past(DATA_OUT_LEVEL))
        else $error("data out level not shown while output disabled");

    // Further guards on stop, buffer, overrun clear, frozen modes and unit reset.
    chk_stopped_idle: assert property (
        !CHANNEL_ENABLED_STATUS |-> !TRANSFER_ACTIVE_FLAG)
        else $error("transfer active while channel stopped");

    chk_write_fills: assert property (
        TX_WRITE |=> BUFFER_FULL_FLAG)
        else $error("buffer full flag not set by a write");

    chk_move_clears: assert property (
        move && !TX_WRITE |=> !BUFFER_FULL_FLAG)
        else $error("buffer full flag not cleared by a move");

    chk_stopped_keeps: assert property (
        BUFFER_FULL_FLAG && !CHANNEL_ENABLED_STATUS |=> BUFFER_FULL_FLAG)
        else $error("stopped channel lost its buffered word");

    chk_overrun_clear: assert property (
        OVERRUN_CLEAR && !ovf_set |=> !OVERRUN_FLAG)
        else $error("overrun flag not cleared");

    chk_mode_frozen: assert property (
        CHANNEL_ENABLED_STATUS |=> $stable(dap_ff) && $stable(ckp_ff) && $stable(len7_ff)
            && $stable(lsb_ff))
        else $error("mode fields changed while running");

    chk_unit_reset: assert property (
        disable iff (SRST) !UNIT_CLOCK_ON |=> !CHANNEL_ENABLED_STATUS && !BUFFER_FULL_FLAG
            && !OVERRUN_FLAG)
        else $error("unit clock removal did not reset the channel");
endmodule

// ===== bench/css_master.sv
// Behavioural serial master that drives the slave's serial clock and data input.
// Assumes the bench calls idle before starting the channel and frame for each word.
`timescale 1ns/100ps

module css_master (
    output logic SCK,
    output logic SIN,
    input wire logic SO
);
    // Both lines start at a defined level.
    initial begin
        SCK = 1'b0;
        SIN = 1'b0;
    end

    // Parks the clock at its idle level, the inverse of the polarity setting.
    task automatic idle(input logic c);
        SCK = ~c;
    endtask

    // Sends one word of n bits and collects the slave's bits in the same order.
    task automatic frame(input logic [7:0] w, input int n, input logic lsb, input logic ckp,
                         input logic dap, output logic [7:0] got);
        int k;
        int b;
        got = 8'h00;
        SCK = ~ckp;
        // Data moves a quarter period away from every edge that samples it.
        for (k = 0; k < n; k++) begin
            b = lsb ? k : n - 1 - k;
            #40;
            SIN = w[b];
            if (dap) got[b] = SO;
            #40;
            SCK = ckp;
            #40;
            if (!dap) got[b] = SO;
            #40;
            SCK = ~ckp;
        end
        #80;
        SIN = ~SIN;
    endtask
endmodule

// ===== bench/tb_css_slave.sv
// Self-checking bench for the serial slave channel, with a behavioural master.
// Assumes the design files and the master model are compiled before it.
`timescale 1ns/100ps

module tb_css_slave;
    logic clk = 1'b0, srst = 1'b1, unit_on = 1'b1, start = 1'b0, stop = 1'b0, oe = 1'b0;
    logic dlev = 1'b1, clev = 1'b1, dap = 1'b0, ckp = 1'b0, len7 = 1'b0, lsb = 1'b0;
    logic isrc = 1'b0, txw = 1'b0, rxr = 1'b0, ovf_clr = 1'b0, s;
    logic sck, sin, so, cko, enabled, full, active, ovf, ev;
    logic [7:0] txd = 8'h00, rxd, got, w, t;
    logic [31:0] seed = 32'h6fbeb72f;
    int mismatches = 0, checks = 0, cycles = 0, i;

    css_master mst (.SCK(sck), .SIN(sin), .SO(so));

    css_slave dut (.CLK(clk), .SRST(srst), .UNIT_CLOCK_ON(unit_on), .SCK(sck), .SIN(sin),
        .SO_OUT(so), .CKO_OUT(cko), .START_TRIGGER(start), .STOP_TRIGGER(stop),
        .CHANNEL_ENABLED_STATUS(enabled), .SERIAL_OUT_ENABLE_BIT(oe), .DATA_OUT_LEVEL(dlev),
        .CLOCK_OUT_LEVEL(clev), .DATA_PHASE_SEL(dap), .CLOCK_POLARITY_SEL(ckp),
        .WORD_LEN7(len7), .LSB_FIRST(lsb), .INTERRUPT_SOURCE_SEL(isrc), .TX_WRITE(txw),
        .TX_DATA(txd), .RX_READ(rxr), .RX_DATA(rxd), .BUFFER_FULL_FLAG(full),
        .TRANSFER_ACTIVE_FLAG(active), .OVERRUN_FLAG(ovf), .OVERRUN_CLEAR(ovf_clr),
        .CHANNEL_EVENT(ev));

    // Operation clock at 40 MHz.
    initial begin
        forever #12.5 clk = ~clk;
    end

    // Cuts a hang short and counts it as a mismatch.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 8000) begin
            mismatches++;
            conclude();
        end
    end

    // Next value of the xorshift sequence.
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Word as it travels when seven bits are selected.
    function automatic logic [7:0] exp_w(input logic [7:0] v, input logic l7);
        return l7 ? {1'b0, v[6:0]} : v;
    endfunction

    // Waits n edges, then lets their updates land before driving or sampling.
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    // Compares a seen value with the expected one.
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        checks++;
        if (seen !== want) begin
            mismatches++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    // Watches for one event pulse within a bounded number of cycles.
    task automatic wait_ev(output logic seen);
        seen = 1'b0;
        repeat (100) begin
            tick(1);
            if (ev === 1'b1) begin
                seen = 1'b1;
                break;
            end
        end
    endtask

    // Raises one input line for a single cycle.
    task automatic pulse(ref logic sig);
        sig = 1'b1;
        tick(1);
        sig = 1'b0;
    endtask

    // Loads a word into the transmit buffer.
    task automatic write_tx(input logic [7:0] d);
        txd = d;
        pulse(txw);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic conclude();
        $display("Counts: %0d checks, %0d mismatches", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Main sequence of scenarios.
    initial begin
        tick(6);
        srst = 1'b0;
        tick(1);
        check(enabled, 8'h00);
        check({full, active, ovf, ev}, 4'h0);
        check(so, 1'b1);
        check(cko, 1'b1);
        dlev = 1'b0;
        clev = 1'b0;
        tick(2);
        check(so, 1'b0);
        check(cko, 1'b0);
        dlev = 1'b1;
        clev = 1'b1;
        $display("test static levels done");
        // Every polarity and phase, with random length, order and event source.
        for (i = 0; i < 4; i++) begin
            seed = xs(seed);
            ckp = i[0];
            dap = i[1];
            len7 = seed[8];
            lsb = seed[9];
            isrc = seed[10];
            t = seed[23:16];
            w = seed[31:24];
            mst.idle(ckp);
            txd = ~t;
            txw = 1'b1;
            tick(1);
            txd = t;
            tick(1);
            txw = 1'b0;
            check(full, 1'b1);
            oe = 1'b1;
            pulse(start);
            check(enabled, 1'b1);
            wait_ev(s);
            check(s, isrc);
            check(full, 1'b0);
            isrc = 1'b0;
            fork
                begin
                    #(seed[4:0]);
                    mst.frame(w, len7 ? 7 : 8, lsb, ckp, dap, got);
                end
                wait_ev(s);
            join
            check(s, 1'b1);
            check(got, exp_w(t, len7));
            check(rxd, exp_w(w, len7));
            check(active, 1'b0);
            pulse(rxr);
            pulse(stop);
            check(enabled, 1'b0);
            oe = 1'b0;
            $display("test mode %0d done", i);
        end
        // Two words without a read in between, then an urgent stop mid-word.
        write_tx(t);
        pulse(start);
        tick(3);
        mst.frame(w, len7 ? 7 : 8, lsb, ckp, dap, got);
        tick(10);
        fork
            mst.frame(~w, len7 ? 7 : 8, lsb, ckp, dap, got);
            wait_ev(s);
        join
        check(s, 1'b1);
        check(ovf, 1'b1);
        check(rxd, exp_w(~w, len7));
        pulse(ovf_clr);
        check(ovf, 1'b0);
        fork
            mst.frame(w, 8, lsb, ckp, dap, got);
            begin
                tick(20);
                check(active, 1'b1);
                pulse(stop);
                check(enabled, 1'b0);
            end
        join
        $display("test overrun and stop done");
        // Removing the unit clock clears the whole unit.
        write_tx(w);
        unit_on = 1'b0;
        tick(2);
        check({full, enabled, ovf}, 3'h0);
        unit_on = 1'b1;
        tick(2);
        $display("test unit clock done");
        conclude();
    end
endmodule
